// File: include/sar_defines.svh
/*
 * Timing counts and field positions of the serial readout block.
 * Assumes a 50 ns system clock; every cycle count except SAR_XCLK_HALF is derived from it.
 */
`ifndef SAR_DEFINES_SVH
`define SAR_DEFINES_SVH

`define SAR_WORD_W        16
`define SAR_MSB           15
`define SAR_CLK_NS        50
// Conversion length, typical figure; busy stays low this long
`define SAR_CONV_NS       18000
`define SAR_CONV_CYC      ((`SAR_CONV_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
// Internal shift clock period, nominal figure; half period rounded down
`define SAR_ICLK_NS       820
`define SAR_ICLK_HALF     ((`SAR_ICLK_NS / 2) / `SAR_CLK_NS)
// Delay from conversion start to the first internal clock pulse
`define SAR_ICLK_DLY_NS   270
`define SAR_ICLK_DLY_CYC  ((`SAR_ICLK_DLY_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_ICLK_PULSES   16
// Shortest convert pulse, rounded up
`define SAR_CONV_PW_NS    40
`define SAR_CONV_PW_CYC   ((`SAR_CONV_PW_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
// Shortest external clock period (10 MHz), half period rounded up
`define SAR_XCLK_MIN_NS   100
`define SAR_XCLK_HALF_MIN ((`SAR_XCLK_MIN_NS / 2 + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_XCLK_HALF     2
// Link clock pulses that carry a new result across before a read
`define SAR_PRIME_PULSES  4
// Pulses per word on the chain: data bits plus one separator
`define SAR_CHAIN_STRIDE  17

`endif

// File: include/sar_pkg.sv
/*
 * Types shared by both ends of the serial readout link.
 * Assumes sar_defines.svh is on the include path.
 */
`include "sar_defines.svh"

package sar_pkg;

	typedef logic [`SAR_WORD_W-1:0] sar_word_t;

	typedef enum logic [1:0] {
		SAR_DS_IDLE = 2'b01,
		SAR_DS_CONV = 2'b10
	} sar_dev_st_t;

	typedef enum logic [5:0] {
		SAR_HS_IDLE  = 6'b000001,
		SAR_HS_START = 6'b000010,
		SAR_HS_WLO   = 6'b000100,
		SAR_HS_WHI   = 6'b001000,
		SAR_HS_PRIME = 6'b010000,
		SAR_HS_READ  = 6'b100000
	} sar_host_st_t;

endpackage

// File: include/sar_if.sv
/*
 * Pins between a converter and its host controller.
 * The shift clock pin is two-way: the host drives it in external mode,
 * the converter in internal mode; the wire level is resolved here.
 * The chain input of a single converter is tied by the surroundings.
 */
`timescale 1ns/1ps

interface sar_if;
	logic sel_b;
	logic rd_conv;
	logic ext_clk_sel;
	logic shift_clk_host;
	logic serial_shift_clock_o;
	logic serial_shift_clock_oe;
	logic serial_shift_clock;
	logic serial_result_out;
	logic chain_in;
	logic busy_b;

	assign serial_shift_clock = serial_shift_clock_oe ? serial_shift_clock_o : shift_clk_host;

	modport dev (
		input  sel_b,
		input  rd_conv,
		input  ext_clk_sel,
		input  serial_shift_clock,
		input  chain_in,
		output serial_shift_clock_o,
		output serial_shift_clock_oe,
		output serial_result_out,
		output busy_b
	);

	modport host (
		output sel_b,
		output rd_conv,
		output ext_clk_sel,
		output shift_clk_host,
		input  serial_result_out,
		input  busy_b
	);
endinterface

// File: core/sar_sync3.sv
/*
 * Three-stage synchroniser; output moves once stages two and three agree.
 * Assumes an asynchronous active-low reset and a clock enable.
 */
`timescale 1ns/1ps

module sar_sync3 #(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_r;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
			q_r  <= INIT;
		end else if (ce_i) begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < W; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					q_r[i] <= s3_r[i];
				end
			end
		end
	end

	assign q_o = q_r;
endmodule // sar_sync3

// File: core/sar_dev.sv
/*
 * Converter end: conversion timing, result handoff into the serial
 * output register, internal-clock burst and daisy-chain pass-through.
 * Assumes the host keeps its own rules; result_i is the conversion
 * engine's word and must be stable at the end of each conversion.
 */
`timescale 1ns/1ps
`include "sar_defines.svh"

// How it works
// - Host ties clock select high for external clock
// - Shift only with select low, read/convert high
// - Host clock up to 10 MHz, 20-70% high
// - Result N readable after or during next conversion
// - Reload mid-conversion; host keeps clock or read low (here word_r reloads at conversion end)
// - Busy rises only once result is held
// - Sixteen bits out MSB first per clock
// - Chain bit per pulse, appears at seventeenth
// - Chain bits keep flowing until next reload
// - Old result readable early; no read until busy
// - Host avoids clocking during a conversion
// - Busy low for the conversion time
// - Internal clock period between 600 and 850 ns
// - Chained units all use the external clock
// - Output after a read equals starting chain level
// - Chain words read in the sampling period
// - Internal mode: sixteen pulses then clock low
module sar_dev #(
	parameter int CONV_CYC   = `SAR_CONV_CYC,
	parameter int ICLK_HALF  = `SAR_ICLK_HALF,
	parameter int ICLK_DLY   = `SAR_ICLK_DLY_CYC,
	parameter int ICLK_PULSE = `SAR_ICLK_PULSES
) (
	sar_if.dev                link,
	input  wire logic         mclk_i,
	input  wire logic         rst_b_i,
	input  wire logic         ce_i,
	input  wire logic [15:0]  result_i,
	output logic              sample_o,
	output logic              done_o
);
	localparam int W = `SAR_WORD_W;

	// System clock side
	logic [3:0]           pin_s;
	logic                 sel_b_s;
	logic                 rd_s;
	logic                 ext_s;
	logic                 tag_s;
	logic                 start_cond_w;
	logic                 start_q_r;
	logic                 start_w;
	logic                 conv_end_w;
	sar_pkg::sar_dev_st_t st_r;
	sar_pkg::sar_dev_st_t st_nxt;
	logic [15:0]          conv_cnt_r;
	logic                 busy_b_r;
	sar_pkg::sar_word_t   word_r;
	logic                 word_tgl_r;
	logic                 sample_r;
	logic                 done_r;

	// Internal-clock burst
	logic                 ib_on_r;
	logic [7:0]           ib_wait_r;
	logic [7:0]           ib_div_r;
	logic                 ib_clk_r;
	logic [4:0]           ib_bits_r;
	sar_pkg::sar_word_t   ib_sr_r;
	logic                 ib_fill_r;
	logic                 ib_edge_w;
	logic                 ib_fall_w;

	// Link clock side
	logic                 tgl_l;
	logic                 seen_r;
	logic                 lk_en_w;
	logic                 lk_pend_w;
	sar_pkg::sar_word_t   lk_sr_r;
	logic                 lk_out_r;

	sar_sync3 #(
		.W    (4),
		.INIT (4'b1111)
	) u_pin_sync (
		.clk_i   (mclk_i),
		.rst_b_i (rst_b_i),
		.ce_i    (ce_i),
		.d_i     ({link.sel_b, link.rd_conv, link.ext_clk_sel, link.chain_in}),
		.q_o     (pin_s)
	);

	assign sel_b_s = pin_s[3];
	assign rd_s    = pin_s[2];
	assign ext_s   = pin_s[1];
	assign tag_s   = pin_s[0];

	// A convert request is the entry into select low with read/convert low
	assign start_cond_w = ~sel_b_s & ~rd_s;
	assign start_w      = start_cond_w & ~start_q_r & (st_r == sar_pkg::SAR_DS_IDLE);
	assign conv_end_w   = (st_r == sar_pkg::SAR_DS_CONV) && (conv_cnt_r == 16'(CONV_CYC - 1));

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			sar_pkg::SAR_DS_IDLE: begin
				if (start_w) begin
					st_nxt = sar_pkg::SAR_DS_CONV;
				end
			end
			sar_pkg::SAR_DS_CONV: begin
				if (conv_end_w) begin
					st_nxt = sar_pkg::SAR_DS_IDLE;
				end
			end
			default: begin
				st_nxt = sar_pkg::SAR_DS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r       <= sar_pkg::SAR_DS_IDLE;
			start_q_r  <= 1'b1;
			conv_cnt_r <= 16'h0000;
			busy_b_r   <= 1'b1;
			sample_r   <= 1'b0;
			done_r     <= 1'b0;
		end else if (ce_i) begin
			st_r       <= st_nxt;
			start_q_r  <= start_cond_w;
			sample_r   <= start_w;
			done_r     <= conv_end_w;
			conv_cnt_r <= (st_r == sar_pkg::SAR_DS_CONV) ? conv_cnt_r + 16'h0001 : 16'h0000;
			busy_b_r   <= (st_nxt != sar_pkg::SAR_DS_CONV);
		end
	end

	// Result is held, then busy rises in the same edge; the link side takes
	// it on the first enabled edge after the toggle has crossed its synchroniser, so the previous word stays readable
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			word_r     <= '0;
			word_tgl_r <= 1'b0;
		end else if (ce_i && conv_end_w) begin
			word_r     <= result_i;
			word_tgl_r <= ~word_tgl_r;
		end
	end

	// Internal clock: previous result on sixteen pulses, then clock low
	assign ib_edge_w = ib_on_r && (ib_wait_r == 8'h00) && (ib_div_r == 8'(ICLK_HALF - 1));
	assign ib_fall_w = ib_edge_w & ib_clk_r;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ib_on_r   <= 1'b0;
			ib_wait_r <= 8'h00;
			ib_div_r  <= 8'h00;
			ib_clk_r  <= 1'b0;
			ib_bits_r <= 5'h00;
			ib_sr_r   <= '0;
			ib_fill_r <= 1'b0;
		end else if (ce_i) begin
			if (start_w && !ext_s) begin
				ib_on_r   <= 1'b1;
				ib_wait_r <= 8'(ICLK_DLY);
				ib_div_r  <= 8'h00;
				ib_clk_r  <= 1'b0;
				ib_bits_r <= 5'h00;
				ib_sr_r   <= word_r;
				ib_fill_r <= tag_s;
			end else if (ib_on_r) begin
				if (ib_wait_r != 8'h00) begin
					ib_wait_r <= ib_wait_r - 8'h01;
				end else if (ib_edge_w) begin
					ib_div_r <= 8'h00;
					ib_clk_r <= ~ib_clk_r;
				end else begin
					ib_div_r <= ib_div_r + 8'h01;
				end
				if (ib_fall_w) begin
					ib_sr_r   <= {ib_sr_r[W-2:0], ib_fill_r};
					ib_bits_r <= ib_bits_r + 5'h01;
					if (ib_bits_r == 5'(ICLK_PULSE - 1)) begin
						ib_on_r <= 1'b0;
					end
				end
			end
		end
	end

	// Link clock domain: result handoff and chain shifting
	sar_sync3 #(
		.W    (1),
		.INIT (1'b0)
	) u_tgl_sync (
		.clk_i   (link.serial_shift_clock),
		.rst_b_i (rst_b_i),
		.ce_i    (1'b1),
		.d_i     (word_tgl_r),
		.q_o     (tgl_l)
	);

	assign lk_en_w   = ~link.sel_b & link.rd_conv;
	assign lk_pend_w = tgl_l ^ seen_r;

	always_ff @(posedge link.serial_shift_clock or negedge rst_b_i) begin
		if (!rst_b_i) begin
			seen_r   <= 1'b0;
			lk_sr_r  <= '0;
			lk_out_r <= 1'b0;
		end else if (lk_en_w) begin
			if (lk_pend_w) begin
				seen_r   <= tgl_l;
				lk_out_r <= word_r[`SAR_MSB];
				lk_sr_r  <= {word_r[W-2:0], link.chain_in};
			end else begin
				lk_out_r <= lk_sr_r[W-1];
				lk_sr_r  <= {lk_sr_r[W-2:0], link.chain_in};
			end
		end
	end

	assign link.serial_result_out     = ext_s ? lk_out_r : ib_sr_r[W-1];
	assign link.serial_shift_clock_o  = ib_clk_r;
	assign link.serial_shift_clock_oe = ~ext_s;
	assign link.busy_b                = busy_b_r;
	assign sample_o                   = sample_r;
	assign done_o                     = done_r;
endmodule // sar_dev

// File: core/sar_host.sv
/*
 * Host end: starts a conversion, waits for busy, then reads NWORDS
 * chained words with a discontinuous external shift clock.
 * Assumes the converters' chain ends on serial_result_out.
 */
`timescale 1ns/1ps
`include "sar_defines.svh"

module sar_host #(
	parameter int NWORDS = 1,
	parameter int HALF   = `SAR_XCLK_HALF,
	parameter int PW     = `SAR_CONV_PW_CYC,
	parameter int PRIME  = `SAR_PRIME_PULSES
) (
	sar_if.host               link,
	input  wire logic         mclk_i,
	input  wire logic         rst_b_i,
	input  wire logic         ce_i,
	input  wire logic         start_i,
	output logic              ready_o,
	output logic [15:0]       word_o,
	output logic              word_valid_o
);
	sar_pkg::sar_host_st_t st_r;
	logic [7:0]            pw_r;
	logic [7:0]            half_r;
	logic                  sclk_r;
	logic [15:0]           pulse_r;
	logic [4:0]            bit_r;
	logic [15:0]           word_r;
	logic                  valid_r;
	logic                  busy_b_s;
	logic                  clocking_w;
	logic                  flip_w;
	logic                  fall_w;
	logic [15:0]           goal_w;

	sar_sync3 #(
		.W    (1),
		.INIT (1'b1)
	) u_busy_sync (
		.clk_i   (mclk_i),
		.rst_b_i (rst_b_i),
		.ce_i    (ce_i),
		.d_i     (link.busy_b),
		.q_o     (busy_b_s)
	);

	assign clocking_w = (st_r == sar_pkg::SAR_HS_PRIME) || (st_r == sar_pkg::SAR_HS_READ);
	assign flip_w     = clocking_w && (half_r == 8'(HALF - 1));
	assign fall_w     = flip_w & sclk_r;
	assign goal_w     = (st_r == sar_pkg::SAR_HS_PRIME) ? 16'(PRIME) :
	                    16'(NWORDS * `SAR_CHAIN_STRIDE);

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r    <= sar_pkg::SAR_HS_IDLE;
			pw_r    <= 8'h00;
			half_r  <= 8'h00;
			sclk_r  <= 1'b0;
			pulse_r <= 16'h0000;
			bit_r   <= 5'h00;
			word_r  <= 16'h0000;
			valid_r <= 1'b0;
		end else if (ce_i) begin
			valid_r <= 1'b0;
			half_r  <= flip_w ? 8'h00 : (clocking_w ? half_r + 8'h01 : 8'h00);
			if (flip_w) begin
				sclk_r <= ~sclk_r;
			end
			case (st_r)
				sar_pkg::SAR_HS_IDLE: begin
					if (start_i) begin
						pw_r <= 8'h00;
						st_r <= sar_pkg::SAR_HS_START;
					end
				end
				sar_pkg::SAR_HS_START: begin
					pw_r <= pw_r + 8'h01;
					if (pw_r == 8'(PW)) begin
						st_r <= sar_pkg::SAR_HS_WLO;
					end
				end
				sar_pkg::SAR_HS_WLO: begin
					if (!busy_b_s) begin
						st_r <= sar_pkg::SAR_HS_WHI;
					end
				end
				sar_pkg::SAR_HS_WHI: begin
					if (busy_b_s) begin
						pulse_r <= 16'h0000;
						st_r    <= sar_pkg::SAR_HS_PRIME;
					end
				end
				sar_pkg::SAR_HS_PRIME, sar_pkg::SAR_HS_READ: begin
					if (fall_w) begin
						pulse_r <= pulse_r + 16'h0001;
						if (pulse_r + 16'h0001 == goal_w) begin
							pulse_r <= 16'h0000;
							bit_r   <= 5'h00;
							st_r    <= (st_r == sar_pkg::SAR_HS_PRIME) ?
							           sar_pkg::SAR_HS_READ : sar_pkg::SAR_HS_IDLE;
						end
					end
					if (fall_w && st_r == sar_pkg::SAR_HS_READ) begin
						bit_r <= (bit_r == 5'(`SAR_CHAIN_STRIDE - 1)) ? 5'h00 : bit_r + 5'h01;
						if (bit_r < 5'(`SAR_WORD_W)) begin
							word_r <= {word_r[14:0], link.serial_result_out};
						end
						if (bit_r == 5'(`SAR_WORD_W - 1)) begin
							valid_r <= 1'b1;
						end
					end
				end
				default: begin
					st_r <= sar_pkg::SAR_HS_IDLE;
				end
			endcase
		end
	end

	// Select stays high while priming: the clock shifts nothing and starts no conversion
	assign link.sel_b          = (st_r == sar_pkg::SAR_HS_IDLE) ||
	                             (st_r == sar_pkg::SAR_HS_PRIME);
	assign link.rd_conv        = (st_r != sar_pkg::SAR_HS_START);
	assign link.ext_clk_sel    = 1'b1;
	assign link.shift_clk_host = sclk_r;
	assign ready_o             = (st_r == sar_pkg::SAR_HS_IDLE);
	assign word_o              = word_r;
	assign word_valid_o        = valid_r;
endmodule // sar_host

// File: bench/sar_link_props.sv
/*
 * Checker for the link between one converter and its host.
 * Assumes the bench holds chain_in steady through each read.
 */
`timescale 1ns/1ps

module sar_link_props #(
	parameter int CONV_CYC = 40
) (
	input  wire logic mclk_i,
	input  wire logic rst_b_i,
	input  wire logic sel_b,
	input  wire logic rd_conv,
	input  wire logic ext_clk_sel,
	input  wire logic serial_shift_clock,
	input  wire logic serial_shift_clock_oe,
	input  wire logic serial_result_out,
	input  wire logic chain_in,
	input  wire logic busy_b
);
	logic [15:0] lo_cnt_r;
	logic [3:0]  cv_age_r;
	logic [5:0]  rd_cnt_r;
	wire         cv_req = !sel_b && !rd_conv;
	wire         rd_en  = !sel_b && rd_conv;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lo_cnt_r <= 16'h0;
			cv_age_r <= 4'hf;
		end else begin
			lo_cnt_r <= busy_b ? 16'h0 : lo_cnt_r + 16'h1;
			cv_age_r <= cv_req ? 4'h0 : cv_age_r + {3'h0, cv_age_r != 4'hf};
		end
	end

	// Enabled link edges since select fell
	always_ff @(posedge serial_shift_clock or negedge rst_b_i) begin
		if (!rst_b_i)
			rd_cnt_r <= 6'h0;
		else if (sel_b)
			rd_cnt_r <= 6'h0;
		else if (rd_en && rd_cnt_r != 6'h3f)
			rd_cnt_r <= rd_cnt_r + 6'h1;
	end

	a_busy_len: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		$rose(busy_b) |-> lo_cnt_r inside {[CONV_CYC-1:CONV_CYC+1]})
		else $error("busy low time off");
	a_busy_cause: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		$fell(busy_b) |-> cv_age_r <= 4'h8)
		else $error("busy fell without convert request");
	a_clk_ext: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		ext_clk_sel)
		else $error("clock source not external");
	a_oe_off: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		ext_clk_sel [*4] |-> !serial_shift_clock_oe)
		else $error("converter drives clock in external mode");
	a_quiet_conv: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!busy_b |-> !serial_shift_clock)
		else $error("clock high during conversion");
	a_clk_high: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		$rose(serial_shift_clock) |=> serial_shift_clock ##1 !serial_shift_clock)
		else $error("shift clock high phase wrong");
	a_shift_edge: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		$changed(serial_result_out) |-> serial_shift_clock && !sel_b)
		else $error("data moved off an enabled edge");
	a_chain_out: assert property (@(negedge serial_shift_clock)
		disable iff (!rst_b_i)
		rd_cnt_r >= 6'h11 && rd_en |-> serial_result_out == chain_in)
		else $error("chain bit not passed through");
endmodule // sar_link_props

// File: bench/test_sar_adc_serial_readout.sv
/*
 * Self-checking bench: one converter and its host joined by the link.
 * Assumes the host reads two words: the result, then the chain bits.
 */
`timescale 1ns/1ps

module test_sar_adc_serial_readout;
	localparam int CONV = 40;
	logic        mclk_i       = 1'b0;
	logic        rst_b_i      = 1'b0;
	logic        start_i      = 1'b0;
	logic        chain_r      = 1'b0;
	logic [15:0] result_i     = 16'h0;
	logic        ready_o;
	logic [15:0] word_o;
	logic        word_valid_o;
	logic        sample_w;
	logic        done_w;
	int          n_samp       = 0;
	int          n_done       = 0;
	logic [31:0] seed         = 32'h3032d17d;
	int          n_fail       = 0;
	int          checked      = 0;
	int          cyc          = 0;

	sar_if link ();
	assign link.chain_in = chain_r;

	sar_dev #(.CONV_CYC(CONV)) i_sar_dev (
		.link     (link.dev),
		.mclk_i   (mclk_i),
		.rst_b_i  (rst_b_i),
		.ce_i     (1'b1),
		.result_i (result_i),
		.sample_o (sample_w),
		.done_o   (done_w)
	);

	sar_host #(.NWORDS(2)) i_sar_host (
		.link         (link.host),
		.mclk_i       (mclk_i),
		.rst_b_i      (rst_b_i),
		.ce_i         (1'b1),
		.start_i      (start_i),
		.ready_o      (ready_o),
		.word_o       (word_o),
		.word_valid_o (word_valid_o)
	);

	sar_link_props #(.CONV_CYC(CONV)) i_sar_link_props (
		.mclk_i                (mclk_i),
		.rst_b_i               (rst_b_i),
		.sel_b                 (link.sel_b),
		.rd_conv               (link.rd_conv),
		.ext_clk_sel           (link.ext_clk_sel),
		.serial_shift_clock    (link.serial_shift_clock),
		.serial_shift_clock_oe (link.serial_shift_clock_oe),
		.serial_result_out     (link.serial_result_out),
		.chain_in              (link.chain_in),
		.busy_b                (link.busy_b)
	);

	initial begin
		forever #25 mclk_i = ~mclk_i;
	end

	// Count conversion starts and result latches, away from the launching edge
	always @(negedge mclk_i) begin
		if (sample_w === 1'b1)
			n_samp++;
		if (done_w === 1'b1)
			n_done++;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Steps at least one edge, then waits for ready (1) or a word (0)
	task automatic wait_for(input bit rdy, input int lim);
		int k;
		k = 0;
		do begin
			@(posedge mclk_i);
			#1;
			k++;
		end while (((rdy ? ready_o : word_valid_o) !== 1'b1) && k < lim);
		if (k >= lim)
			check("handshake wait", 16'h1, 16'h0);
	endtask

	task automatic run_op(input logic [15:0] res, input logic c);
		int s0;
		int d0;
		@(posedge mclk_i);
		s0 = n_samp;
		d0 = n_done;
		result_i <= res;
		chain_r  <= c;
		start_i  <= 1'b1;
		// Extra start cycles while the host is busy must be ignored
		repeat (3) @(posedge mclk_i);
		start_i <= 1'b0;
		#1;
		check("ready while busy", {15'h0, ready_o}, 16'h0);
		wait_for(1'b0, 2000);
		check("result word", word_o, res);
		wait_for(1'b0, 400);
		check("chain word", word_o, {16{c}});
		wait_for(1'b1, 400);
		check("line after read", {15'h0, link.serial_result_out}, {15'h0, c});
		check("starts per read", 16'(n_samp - s0), 16'h1);
		check("latches per read", 16'(n_done - d0), 16'h1);
	endtask

	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			complete_run();
		end
	end

	initial begin
		logic [15:0] corner [4];
		corner = '{16'h8000, 16'h0001, 16'hffff, 16'h0000};
		repeat (20) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 4; i++)
			run_op(corner[i], i[0]);
		for (int i = 0; i < 12; i++) begin
			seed = xs(seed);
			run_op(seed[15:0], seed[16]);
		end
		// Reset in the middle of a conversion, then carry on
		@(posedge mclk_i);
		start_i <= 1'b1;
		@(posedge mclk_i);
		start_i <= 1'b0;
		repeat (20) @(posedge mclk_i);
		rst_b_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		check("busy in reset", {15'h0, link.busy_b}, 16'h1);
		check("ready in reset", {15'h0, ready_o}, 16'h1);
		repeat (4) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		run_op(16'ha5c3, 1'b1);
		complete_run();
	end
endmodule // test_sar_adc_serial_readout
